// *** rtl/qmed_pkg.sv ***
// constants, field layout and carrier types for the quad mode enable descriptor block
// assumes one 125 MHz clock and a plain register port with read data one cycle later
`default_nettype none

package qmed_pkg;

  // register port
  localparam int unsigned QMED_AW = 8;
  localparam int unsigned QMED_DW = 32;
  localparam logic [7:0] QMED_OFS_DESC = 8'h00;
  localparam logic [7:0] QMED_OFS_CFG0 = 8'h04;
  localparam logic [7:0] QMED_OFS_CFG1 = 8'h08;
  localparam logic [7:0] QMED_OFS_CTRL = 8'h0C;
  localparam logic [7:0] QMED_OFS_STAT = 8'h10;
  localparam logic [7:0] QMED_OFS_QREG = 8'h14;

  // descriptor field positions
  localparam int unsigned QMED_B_AVAIL = 31;
  localparam int unsigned QMED_B_POL = 30;
  localparam int unsigned QMED_B_RSVD = 29;
  localparam int unsigned QMED_B_ADDRD = 28;
  localparam int unsigned QMED_B_BYTE1 = 27;
  localparam int unsigned QMED_F_POS = 24;
  localparam int unsigned QMED_F_LOC = 16;
  localparam int unsigned QMED_B_8D = 23;
  localparam int unsigned QMED_B_8S = 22;
  localparam int unsigned QMED_B_4D = 21;
  localparam int unsigned QMED_B_4S = 20;
  localparam int unsigned QMED_F_DUM = 16;
  localparam int unsigned QMED_F_RDOP = 8;
  localparam int unsigned QMED_F_WROP = 0;

  // configuration, control and status register field positions
  localparam int unsigned QMED_C0_MODES = 12;
  localparam int unsigned QMED_C0_DUM = 8;
  localparam int unsigned QMED_C0_AW = 0;
  localparam int unsigned QMED_CTRL_PUB = 0;
  localparam int unsigned QMED_CTRL_CLR = 1;
  localparam int unsigned QMED_ST_ERR = 16;
  localparam int unsigned QMED_ST_QUAD = 17;

  // reset values
  localparam logic [31:0] QMED_DESC_RST = 32'h0000_0000;
  localparam logic [7:0] QMED_QREG_RST = 8'h00;
  localparam logic [7:0] QMED_OP_NONE = 8'h00;

  typedef enum logic [1:0] {
    QMED_ADDR8 = 2'h0,
    QMED_ADDR24 = 2'h1,
    QMED_ADDR32 = 2'h2
  } qmed_aw_t;

  // lane mode of an incoming command
  typedef enum logic [2:0] {
    QMED_M111 = 3'h0,
    QMED_M4S = 3'h1,
    QMED_M4D = 3'h2,
    QMED_M8S = 3'h3,
    QMED_M8D = 3'h4
  } qmed_mode_t;

  typedef struct packed {
    logic avail;
    logic pol;
    logic addressed;
    logic byte1;
    logic [2:0] bitpos;
    logic [7:0] laddr;
    logic [3:0] modes; // 8D, 8S, 4D, 4S from high to low
    logic [3:0] dummy;
    logic [7:0] rd_op;
    logic [7:0] wr_op;
    qmed_aw_t aw;
  } qmed_cfg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    qmed_mode_t mode;
    logic [3:0] dummy;
    logic addressed;
    logic [31:0] addr;
    logic [7:0] wdata;
  } qmed_cmd_t;

  typedef struct packed {
    logic done;
    logic ok;
    logic [7:0] rdata;
  } qmed_resp_t;

endpackage

`default_nettype wire

// *** rtl/qmed_encode.sv ***
// packs the configuration into the published descriptor word
// assumes the configuration is registered upstream; purely combinational
`default_nettype none

module qmed_encode
  import qmed_pkg::*;
(
  input wire qmed_cfg_t cfg, // staged configuration
  output logic [31:0] desc, // encoded descriptor
  output logic err // byte 1 placement asked with 8-bit addressing
);

  // one field at a time so unused bits stay zero
  always_comb begin
    desc = '0;
    desc[QMED_B_AVAIL] = cfg.avail;
    desc[QMED_B_POL] = cfg.pol;
    desc[QMED_B_RSVD] = 1'b0;
    desc[QMED_B_ADDRD] = cfg.addressed;
    // byte 1 placement makes no sense on an 8-bit address, so it is dropped
    desc[QMED_B_BYTE1] = cfg.byte1 && (cfg.aw != QMED_ADDR8);
    desc[QMED_F_POS +: 3] = cfg.bitpos;
    if (cfg.addressed) begin
      desc[QMED_F_LOC +: 8] = cfg.laddr;
    end else begin
      desc[QMED_B_8D] = cfg.modes[3];
      desc[QMED_B_8S] = cfg.modes[2];
      desc[QMED_B_4D] = cfg.modes[1];
      desc[QMED_B_4S] = cfg.modes[0];
      desc[QMED_F_DUM +: 4] = cfg.dummy;
    end
    desc[QMED_F_RDOP +: 8] = cfg.rd_op;
    desc[QMED_F_WROP +: 8] = cfg.wr_op;
    err = cfg.byte1 && (cfg.aw == QMED_ADDR8);
  end

endmodule

`default_nettype wire

// *** rtl/qmed_top.sv ***
// quad mode enable descriptor: staging registers, published word and command checker
// assumes commands arrive already deserialised, one cycle each, synchronous to clk
`default_nettype none

module qmed_top
  import qmed_pkg::*;
(
  input wire logic clk, // 125 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic [QMED_AW-1:0] reg_addr, // register byte address
  input wire logic [QMED_DW-1:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [QMED_DW-1:0] reg_rdata, // read data, cycle after reg_rd
  output logic [31:0] desc_word, // descriptor as published to the table
  input wire qmed_cmd_t cmd, // decoded enable-bit command
  output qmed_resp_t resp, // command answer, cycle after cmd.valid
  output logic quad_mode // quad mode selected by the enable bit
);

  typedef struct packed {
    qmed_cfg_t cfg;
    logic [31:0] desc;
    logic cfg_err;
    logic [7:0] qreg;
    logic [7:0] rej_cnt;
    logic quad;
    logic [31:0] rdata;
    qmed_resp_t resp;
  } qmed_st_t;

  qmed_st_t s_r;
  qmed_st_t s_nxt;
  logic [31:0] enc_desc;
  logic enc_err;

  qmed_encode u_enc (
    .cfg (s_r.cfg),
    .desc (enc_desc),
    .err (enc_err)
  );

  // command decode always works on the published word, so the memory answers
  // exactly what the host was told even while new settings are being staged
  logic hit_rd;
  logic hit_wr;
  logic [7:0] loc_seen;
  logic mode_ok;
  logic path_ok;
  logic [3:0] dum_cfg;

  always_comb begin
    dum_cfg = s_r.desc[QMED_F_DUM +: 4];
    // an all-zero opcode never matches, so unsupported access is refused
    hit_rd = (cmd.opcode == s_r.desc[QMED_F_RDOP +: 8]) &&
             (s_r.desc[QMED_F_RDOP +: 8] != QMED_OP_NONE);
    hit_wr = (cmd.opcode == s_r.desc[QMED_F_WROP +: 8]) &&
             (s_r.desc[QMED_F_WROP +: 8] != QMED_OP_NONE);
    // local address taken from byte 1 or byte 0 as published
    loc_seen = s_r.desc[QMED_B_BYTE1] ? cmd.addr[15:8] : cmd.addr[7:0];
    // only the exact published dummy count is honoured in a flagged mode
    case (cmd.mode)
      QMED_M111: mode_ok = (cmd.dummy == 4'h0);
      QMED_M4S: mode_ok = s_r.desc[QMED_B_4S] && (cmd.dummy == dum_cfg);
      QMED_M4D: mode_ok = s_r.desc[QMED_B_4D] && (cmd.dummy == dum_cfg);
      QMED_M8S: mode_ok = s_r.desc[QMED_B_8S] && (cmd.dummy == dum_cfg);
      QMED_M8D: mode_ok = s_r.desc[QMED_B_8D] && (cmd.dummy == dum_cfg);
      default: mode_ok = 1'b0;
    endcase
    if (s_r.desc[QMED_B_ADDRD]) begin
      path_ok = cmd.addressed && (loc_seen == s_r.desc[QMED_F_LOC +: 8]);
    end else begin
      path_ok = !cmd.addressed && mode_ok;
    end
    path_ok = path_ok && s_r.desc[QMED_B_AVAIL];
  end

  // next state: register writes, publish, command effects, read mux
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = '0;
    s_nxt.resp = '0;
    if (reg_wr) begin
      if (reg_addr == QMED_OFS_CFG0) begin
        s_nxt.cfg.avail = reg_wdata[QMED_B_AVAIL];
        s_nxt.cfg.pol = reg_wdata[QMED_B_POL];
        s_nxt.cfg.addressed = reg_wdata[QMED_B_ADDRD];
        s_nxt.cfg.byte1 = reg_wdata[QMED_B_BYTE1];
        s_nxt.cfg.bitpos = reg_wdata[QMED_F_POS +: 3];
        s_nxt.cfg.laddr = reg_wdata[QMED_F_LOC +: 8];
        s_nxt.cfg.modes = reg_wdata[QMED_C0_MODES +: 4];
        s_nxt.cfg.dummy = reg_wdata[QMED_C0_DUM +: 4];
        s_nxt.cfg.aw = qmed_aw_t'(reg_wdata[QMED_C0_AW +: 2]);
      end else if (reg_addr == QMED_OFS_CFG1) begin
        s_nxt.cfg.rd_op = reg_wdata[QMED_F_RDOP +: 8];
        s_nxt.cfg.wr_op = reg_wdata[QMED_F_WROP +: 8];
      end else if (reg_addr == QMED_OFS_CTRL) begin
        if (reg_wdata[QMED_CTRL_PUB]) begin
          s_nxt.desc = enc_desc;
          s_nxt.cfg_err = enc_err;
        end
        if (reg_wdata[QMED_CTRL_CLR]) begin
          s_nxt.rej_cnt = '0;
        end
      end else if (reg_addr == QMED_OFS_QREG) begin
        s_nxt.qreg = reg_wdata[7:0];
      end
    end
    // a command lands after the software write so the memory side wins a tie;
    // a reject in the clearing cycle still counts
    if (cmd.valid) begin
      s_nxt.resp.done = 1'b1;
      s_nxt.resp.ok = path_ok && (hit_rd || hit_wr);
      if (path_ok && hit_rd) begin
        s_nxt.resp.rdata = s_r.qreg;
      end else if (path_ok && hit_wr) begin
        s_nxt.qreg = cmd.wdata;
      end else begin
        s_nxt.rej_cnt = s_nxt.rej_cnt + 8'h01;
      end
    end
    // enable level interpreted through the published polarity
    s_nxt.quad = s_nxt.desc[QMED_B_AVAIL] &&
                 (s_nxt.qreg[s_nxt.desc[QMED_F_POS +: 3]] ^ s_nxt.desc[QMED_B_POL]);
    if (reg_rd) begin
      if (reg_addr == QMED_OFS_DESC) begin
        s_nxt.rdata = s_r.desc;
      end else if (reg_addr == QMED_OFS_CFG0) begin
        s_nxt.rdata = {s_r.cfg.avail, s_r.cfg.pol, 1'b0, s_r.cfg.addressed, s_r.cfg.byte1,
                       s_r.cfg.bitpos, s_r.cfg.laddr, s_r.cfg.modes, s_r.cfg.dummy,
                       6'h00, s_r.cfg.aw};
      end else if (reg_addr == QMED_OFS_CFG1) begin
        s_nxt.rdata = {16'h0000, s_r.cfg.rd_op, s_r.cfg.wr_op};
      end else if (reg_addr == QMED_OFS_STAT) begin
        s_nxt.rdata = {14'h0000, s_r.quad, s_r.cfg_err, 8'h00, s_r.rej_cnt};
      end else if (reg_addr == QMED_OFS_QREG) begin
        s_nxt.rdata = {24'h000000, s_r.qreg};
      end
    end
  end

  // single state register; reset gives a descriptor saying nothing is supported
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.desc <= QMED_DESC_RST;
      s_r.qreg <= QMED_QREG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign desc_word = s_r.desc;
  assign resp = s_r.resp;
  assign quad_mode = s_r.quad;

  // checks on the published word and on command answers
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_publish;
    reg_wr && (reg_addr == QMED_OFS_CTRL) && reg_wdata[QMED_CTRL_PUB];
  endsequence

  sequence s_direct_cmd;
    cmd.valid && s_r.desc[QMED_B_AVAIL] && !s_r.desc[QMED_B_ADDRD] && !cmd.addressed;
  endsequence

  property p_avail;
    s_publish |=> desc_word[QMED_B_AVAIL] == $past(s_r.cfg.avail);
  endproperty
  a_avail: assert property (p_avail) else $error("availability bit not published");

  property p_polarity;
    s_publish ##1 !reg_wr [*2] |-> quad_mode ==
      (desc_word[QMED_B_AVAIL] && (s_r.qreg[desc_word[QMED_F_POS +: 3]] ^ desc_word[QMED_B_POL]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("quad mode ignores polarity");

  property p_reserved;
    s_publish |=> !desc_word[QMED_B_RSVD] ##1 !desc_word[QMED_B_RSVD];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit published as one");

  property p_method;
    s_publish and (s_r.cfg.addressed) |=> desc_word[QMED_B_ADDRD] &&
      desc_word[QMED_F_LOC +: 8] == $past(s_r.cfg.laddr);
  endproperty
  a_method: assert property (p_method) else $error("addressed method or address wrong");

  property p_byte1_8bit;
    s_publish and (s_r.cfg.aw == QMED_ADDR8) |=> !desc_word[QMED_B_BYTE1] && s_r.cfg_err ==
      $past(s_r.cfg.byte1);
  endproperty
  a_byte1_8bit: assert property (p_byte1_8bit) else $error("byte 1 placement on 8-bit");

  property p_bitpos;
    s_publish |=> desc_word[QMED_F_POS +: 3] == $past(s_r.cfg.bitpos);
  endproperty
  a_bitpos: assert property (p_bitpos) else $error("bit position not published");

  property p_addr_match;
    cmd.valid && s_r.desc[QMED_B_ADDRD] && cmd.addressed &&
      (loc_seen != s_r.desc[QMED_F_LOC +: 8]) |=> resp.done && !resp.ok;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("wrong local address accepted");

  property p_octal_flags;
    s_publish and (!s_r.cfg.addressed) |=> desc_word[QMED_B_8D] == $past(s_r.cfg.modes[3]) &&
      desc_word[QMED_B_8S] == $past(s_r.cfg.modes[2]);
  endproperty
  a_octal_flags: assert property (p_octal_flags) else $error("octal flags wrong");

  property p_quad_dummy;
    s_direct_cmd and (cmd.mode == QMED_M4S) and (cmd.dummy != s_r.desc[QMED_F_DUM +: 4])
      |=> resp.done && !resp.ok;
  endproperty
  a_quad_dummy: assert property (p_quad_dummy) else $error("wrong dummy count accepted");

  property p_single_lane;
    s_direct_cmd and (cmd.mode == QMED_M111) and (cmd.dummy == 4'h0) and hit_rd
      |=> resp.done && resp.ok && resp.rdata == $past(s_r.qreg);
  endproperty
  a_single_lane: assert property (p_single_lane) else $error("1-1-1 read refused");

  property p_no_op;
    cmd.valid && (cmd.opcode == QMED_OP_NONE) |=> resp.done && !resp.ok;
  endproperty
  a_no_op: assert property (p_no_op) else $error("zero opcode accepted");

  property p_write_back;
    cmd.valid && path_ok && hit_wr && !hit_rd |=> resp.ok && s_r.qreg == $past(cmd.wdata);
  endproperty
  a_write_back: assert property (p_write_back) else $error("enable byte not written");

  // remaining published fields, and the refusals that the host relies on
  property p_quad_flags;
    s_publish and (!s_r.cfg.addressed) |=> desc_word[QMED_B_4D] == $past(s_r.cfg.modes[1]) &&
      desc_word[QMED_B_4S] == $past(s_r.cfg.modes[0]);
  endproperty
  a_quad_flags: assert property (p_quad_flags) else $error("quad flags wrong");

  property p_dummy_pub;
    s_publish and (!s_r.cfg.addressed) |=> desc_word[QMED_F_DUM +: 4] == $past(s_r.cfg.dummy);
  endproperty
  a_dummy_pub: assert property (p_dummy_pub) else $error("dummy count not published");

  property p_opcodes;
    s_publish |=> desc_word[QMED_F_RDOP +: 8] == $past(s_r.cfg.rd_op) &&
      desc_word[QMED_F_WROP +: 8] == $past(s_r.cfg.wr_op);
  endproperty
  a_opcodes: assert property (p_opcodes) else $error("opcodes not published");

  // between publishes the table must not move under a host that has already read it
  property p_desc_hold;
    !(reg_wr && (reg_addr == QMED_OFS_CTRL) && reg_wdata[QMED_CTRL_PUB]) |=> $stable(desc_word);
  endproperty
  a_desc_hold: assert property (p_desc_hold) else $error("table changed unpublished");

  property p_unavail;
    cmd.valid && !s_r.desc[QMED_B_AVAIL] |=> resp.done && !resp.ok;
  endproperty
  a_unavail: assert property (p_unavail) else $error("unavailable bit accessed");

  property p_octal_refuse;
    s_direct_cmd and (cmd.mode == QMED_M8S) and (!s_r.desc[QMED_B_8S])
      |=> resp.done && !resp.ok;
  endproperty
  a_octal_refuse: assert property (p_octal_refuse) else $error("octal mode taken unflagged");

  property p_quad_refuse;
    s_direct_cmd and (cmd.mode == QMED_M4S) and (!s_r.desc[QMED_B_4S])
      |=> resp.done && !resp.ok;
  endproperty
  a_quad_refuse: assert property (p_quad_refuse) else $error("quad mode taken unflagged");

  // an addressed read with the local address where the table puts it must succeed
  property p_addr_read;
    cmd.valid && s_r.desc[QMED_B_AVAIL] && s_r.desc[QMED_B_ADDRD] && cmd.addressed && hit_rd &&
      (loc_seen == s_r.desc[QMED_F_LOC +: 8])
      |=> resp.done && resp.ok && resp.rdata == $past(s_r.qreg);
  endproperty
  a_addr_read: assert property (p_addr_read) else $error("addressed read refused");

  // the level follows the written byte's bit through the polarity, not the old byte
  property p_quad_write;
    cmd.valid && path_ok && hit_wr && !hit_rd && !reg_wr |=>
      quad_mode == (|(($past(cmd.wdata) >> desc_word[QMED_F_POS +: 3]) & 8'h01) ^
      desc_word[QMED_B_POL]);
  endproperty
  a_quad_write: assert property (p_quad_write) else $error("quad level after write");

  property p_reject_count;
    cmd.valid && !(path_ok && (hit_rd || hit_wr)) && !reg_wr |=>
      s_r.rej_cnt == $past(s_r.rej_cnt) + 8'h01;
  endproperty
  a_reject_count: assert property (p_reject_count) else $error("refusal not counted");

  property p_resp_pulse;
    !cmd.valid |=> !resp.done && !resp.ok && (resp.rdata == 8'h00);
  endproperty
  a_resp_pulse: assert property (p_resp_pulse) else $error("answer without command");

endmodule

`default_nettype wire

// *** testbench/qmed_host_model.sv ***
// host-side model: reads the published descriptor and issues enable-bit commands
// assumes the device answers one cycle after each command, on the same clock
`default_nettype none

module qmed_host_model
  import qmed_pkg::*;
(
  input wire logic clk, // device clock
  input wire logic [31:0] desc_word, // published descriptor
  input wire qmed_resp_t resp, // device answer
  output qmed_cmd_t cmd // command to the device
);
  // idle until the bench asks for a command
  initial cmd = '0;

  // one command; flt[0] puts the address in the wrong byte, flt[1] flips the method
  task automatic send(input logic wr, input qmed_mode_t md, input logic [3:0] dm,
                      input logic [7:0] wd, input logic [1:0] flt,
                      output logic dn, output logic ok, output logic [7:0] rd);
    logic [7:0] la;
    la = desc_word[23:16];
    @(posedge clk);
    cmd.valid <= 1'b1;
    cmd.opcode <= wr ? desc_word[7:0] : desc_word[15:8];
    cmd.mode <= md;
    cmd.dummy <= dm;
    cmd.addressed <= desc_word[28] ^ flt[1];
    // filler bytes differ from the local address so a wrong pick shows
    if (desc_word[27] ^ flt[0])
      cmd.addr <= {~la, ~la, la, ~la};
    else
      cmd.addr <= {~la, ~la, ~la, la};
    cmd.wdata <= wd;
    @(posedge clk);
    cmd.valid <= 1'b0;
    cmd.wdata <= ~wd;
    // the answer stands for this one cycle only, so look at it mid-cycle
    @(negedge clk);
    dn = resp.done;
    ok = resp.ok;
    rd = resp.rdata;
  endtask

  // read the byte, change only the enable bit by polarity, write it back
  task automatic set_quad(input logic en, output logic ok);
    logic dn1, dn2, ok1, ok2;
    logic [7:0] v, junk;
    send(1'b0, QMED_M111, 4'h0, 8'h00, 2'b00, dn1, ok1, v);
    v[desc_word[26:24]] = en ^ desc_word[30];
    send(1'b1, QMED_M111, 4'h0, v, 2'b00, dn2, ok2, junk);
    ok = dn1 & ok1 & dn2 & ok2;
  endtask
endmodule

`default_nettype wire

// *** testbench/tb_quad_mode_enable_descriptor_decode.sv ***
// self-checking bench for the quad mode enable descriptor block
// assumes the host model is compiled first and drives the command port
`default_nettype none

module tb_quad_mode_enable_descriptor_decode
  import qmed_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, desc_word;
  qmed_cmd_t cmd;
  qmed_resp_t resp;
  logic quad_mode;
  int num_errors = 0;
  int n_checks = 0;

  // 125 MHz clock
  always #4 clk = ~clk;

  qmed_top dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .desc_word(desc_word),
    .cmd(cmd), .resp(resp), .quad_mode(quad_mode));

  qmed_host_model host_u (.clk(clk), .desc_word(desc_word), .resp(resp), .cmd(cmd));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  // register port: one-cycle strobes, read data taken in the cycle after
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // read data stand only in this cycle; the next edge clears them
    @(negedge clk);
    d = reg_rdata;
  endtask

  // stage both configuration words and publish them
  task automatic cfg(input logic [31:0] c0, input logic [31:0] c1);
    wr_reg(QMED_OFS_CFG0, c0);
    wr_reg(QMED_OFS_CFG1, c1);
    wr_reg(QMED_OFS_CTRL, 32'h0000_0001);
    @(posedge clk);
  endtask

  task automatic cmd_chk(input logic wr, input qmed_mode_t md, input logic [3:0] dm,
                         input logic [1:0] flt, input logic e);
    logic dn, ok;
    logic [7:0] rd;
    host_u.send(wr, md, dm, 8'h00, flt, dn, ok, rd);
    chk("cmd done", 32'h1, {31'h0, dn});
    chk("cmd ok", {31'h0, e}, {31'h0, ok});
  endtask

  task automatic t_reset;
    logic [31:0] d;
    chk("desc", 32'h0, desc_word);
    wr_reg(QMED_OFS_DESC, 32'hFFFF_FFFF);
    rd_reg(QMED_OFS_DESC, d);
    chk("desc read", 32'h0, d);
    rd_reg(8'h3C, d);
    chk("unmapped", 32'h0, d);
    cmd_chk(1'b0, QMED_M111, 4'h0, 2'b00, 1'b0);
    chk("quad", 32'h0, {31'h0, quad_mode});
    rd_reg(QMED_OFS_STAT, d);
    chk("reject count", 32'h1, d);
    wr_reg(QMED_OFS_CTRL, 32'h0000_0002);
    rd_reg(QMED_OFS_STAT, d);
    chk("reject clear", 32'h0, d);
    $display("test reset done");
  endtask

  // direct method: flags 8D and 4D at five dummy cycles, reserved bit staged high
  task automatic t_direct;
    logic [31:0] d;
    logic ok;
    logic dn;
    logic [7:0] rb;
    cfg(32'hA300_A502, 32'h0000_0501);
    chk("desc", 32'h83A5_0501, desc_word);
    rd_reg(QMED_OFS_DESC, d);
    chk("desc read", 32'h83A5_0501, d);
    rd_reg(QMED_OFS_CFG0, d);
    chk("cfg0 read", 32'h8300_A502, d);
    rd_reg(QMED_OFS_CFG1, d);
    chk("cfg1 read", 32'h0000_0501, d);
    cmd_chk(1'b0, QMED_M111, 4'h0, 2'b00, 1'b1);
    cmd_chk(1'b0, QMED_M111, 4'h5, 2'b00, 1'b0);
    cmd_chk(1'b0, QMED_M4S, 4'h5, 2'b00, 1'b0);
    cmd_chk(1'b0, QMED_M4S, 4'h4, 2'b00, 1'b0);
    cmd_chk(1'b0, QMED_M4D, 4'h4, 2'b00, 1'b0);
    cmd_chk(1'b0, QMED_M4D, 4'h5, 2'b00, 1'b1);
    cmd_chk(1'b0, QMED_M8S, 4'h5, 2'b00, 1'b0);
    cmd_chk(1'b0, QMED_M8D, 4'h5, 2'b00, 1'b1);
    cmd_chk(1'b0, QMED_M8D, 4'h4, 2'b00, 1'b0);
    cmd_chk(1'b0, QMED_M111, 4'h0, 2'b10, 1'b0);
    host_u.set_quad(1'b1, ok);
    chk("rmw", 32'h1, {31'h0, ok});
    rd_reg(QMED_OFS_QREG, d);
    chk("qreg", 32'h0000_0008, d);
    chk("quad", 32'h1, {31'h0, quad_mode});
    host_u.send(1'b0, QMED_M111, 4'h0, 8'h00, 2'b00, dn, ok, rb);
    chk("cmd rdata", 32'h0000_0308, {22'h0, dn, ok, rb});
    cfg(32'hA300_A502, 32'h0000_0001);
    cmd_chk(1'b0, QMED_M111, 4'h0, 2'b00, 1'b0);
    cmd_chk(1'b1, QMED_M111, 4'h0, 2'b00, 1'b1);
    cfg(32'hA300_A502, 32'h0000_0500);
    cmd_chk(1'b1, QMED_M111, 4'h0, 2'b00, 1'b0);
    $display("test direct done");
  endtask

  // addressed method, byte 1 placement, inverted polarity, bit 7
  task automatic t_addr;
    logic [31:0] d;
    logic ok;
    cfg(32'hDFA5_FF01, 32'h0000_3531);
    chk("desc", 32'hDFA5_3531, desc_word);
    cmd_chk(1'b0, QMED_M111, 4'h0, 2'b00, 1'b1);
    cmd_chk(1'b0, QMED_M111, 4'h0, 2'b01, 1'b0);
    cmd_chk(1'b0, QMED_M111, 4'h0, 2'b10, 1'b0);
    host_u.set_quad(1'b1, ok);
    chk("rmw", 32'h1, {31'h0, ok});
    chk("quad", 32'h1, {31'h0, quad_mode});
    host_u.set_quad(1'b0, ok);
    chk("rmw", 32'h1, {31'h0, ok});
    chk("quad", 32'h0, {31'h0, quad_mode});
    rd_reg(QMED_OFS_QREG, d);
    chk("qreg", 32'h0000_0080, d);
    cfg(32'hDFA5_FF00, 32'h0000_3531);
    chk("desc", 32'hD7A5_3531, desc_word);
    rd_reg(QMED_OFS_STAT, d);
    chk("cfg err", 32'h1, {31'h0, d[QMED_ST_ERR]});
    cmd_chk(1'b0, QMED_M111, 4'h0, 2'b00, 1'b1);
    $display("test addressed done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence: reset for 12 cycles, then the tests
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_direct();
    t_addr();
    report_and_stop();
  end

  // tests need well under a thousand cycles; a hang ends here
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule

`default_nettype wire
